// [hw/e1pc_pkg.sv]
// Purpose: Constants for the E1 port and test configuration block
// Assumes: AXI4-Lite register access, 10 MHz aclk
// Notes:   Offsets are byte addresses of 32-bit words
`default_nettype none

package e1pc_pkg;

    // ==========================================================
    // Register map
    localparam logic [5:0] OFS_SYS   = 6'h00;
    localparam logic [5:0] OFS_DUR   = 6'h04;
    localparam logic [5:0] OFS_PSEL  = 6'h08;
    localparam logic [5:0] OFS_PCFG  = 6'h0c;
    localparam logic [5:0] OFS_PID   = 6'h10;
    localparam logic [5:0] OFS_COPY  = 6'h14;
    localparam logic [5:0] OFS_STAT  = 6'h18;
    localparam logic [5:0] OFS_ISTAT = 6'h1c;
    localparam logic [5:0] OFS_IMASK = 6'h20;

    // ==========================================================
    // Field positions
    localparam int SYS_ROLE_NT = 0;
    localparam int SYS_AUTO    = 1;
    localparam int SYS_R2064   = 2;
    localparam int SYS_TMO_EN  = 3;
    localparam int SYS_TELCO   = 4;
    localparam int SYS_REMOTE  = 5;
    localparam int CFG_EN      = 0;
    localparam int CFG_UNFR    = 1;
    localparam int CFG_AMI     = 2;
    localparam int CFG_CRC4    = 3;
    localparam int CFG_TS16    = 4;
    localparam int CFG_CLKLN   = 6;
    localparam int CP_ALL      = 6;
    localparam int CP_INCR     = 7;
    localparam int EV_TMO      = 0;
    localparam int EV_TELCO    = 1;
    localparam int EV_COPY     = 2;
    localparam int EV_ROLE     = 3;

    // ==========================================================
    // Reset values and encodings
    localparam logic [5:0] SYS_RST   = 6'h18;
    localparam logic [6:0] CFG_RST   = 7'h11;
    localparam logic [6:0] CFG_WMASK = 7'h7e;
    localparam logic [1:0] TS16_CAS  = 2'h0;
    localparam logic [1:0] TS16_CCS  = 2'h1;
    localparam logic [1:0] TS16_DATA = 2'h2;
    localparam logic [6:0] DUR_RST   = 7'h0a;
    localparam logic [6:0] DUR_MIN   = 7'h01;
    localparam logic [6:0] DUR_MAX   = 7'h78;
    localparam logic [1:0] RESP_OK   = 2'h0;
    localparam logic [1:0] RESP_ERR  = 2'h2;

    // ==========================================================
    // Timing
    localparam longint CLK_NS      = 100;
    localparam longint MINUTE_NS   = 64'd60_000_000_000;
    localparam longint CYC_PER_MIN = MINUTE_NS / CLK_NS;

    typedef enum logic [1:0] {E1PC_IDLE = 2'b00, E1PC_RUN = 2'b01} e1pc_test_t;

endpackage

`default_nettype wire

// [hw/e1pc_top.sv]
// Purpose: E1 port options, copy engine, card role and test timer
// Assumes: One clock, line-side inputs asynchronous, AXI4-Lite slave
// Notes:   All outputs registered; config of port n is per-port array
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`default_nettype none

module e1pc_top
    import e1pc_pkg::*;
#(
    parameter int NPORT   = 8,
    parameter int MIN_CYC = int'(CYC_PER_MIN)
)(
    // Clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // AXI4-Lite slave
    input  wire logic [5:0]         awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [5:0]         araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    // Line side, asynchronous
    input  wire logic               far_crc4,
    input  wire logic               telco_lb_cmd,
    input  wire logic               link_setup,
    // Port status from same-clock logic
    input  wire logic [NPORT-1:0]   alarm_in,
    input  wire logic [NPORT-1:0]   led_req,
    input  wire logic               test_start,
    input  wire logic               test_stop,
    // Per-port controls
    output logic [NPORT-1:0]        port_en,
    output logic [NPORT-1:0]        framing_on,
    output logic [NPORT-1:0]        whole_line_bypass_mode,
    output logic [NPORT-1:0]        line_ami,
    output logic [NPORT-1:0]        crc4_on,
    output logic [2*NPORT-1:0]      ts16_mode,
    output logic [NPORT-1:0]        clk_from_line,
    output logic [NPORT-1:0]        alarm_out,
    output logic [NPORT-1:0]        led_out,
    // Card level
    output logic                    card_reset,
    output logic                    addr_request,
    output logic                    test_active,
    output logic                    lb_local,
    output logic                    lb_remote,
    output logic                    irq
);

    localparam int PW = $clog2(NPORT);

    // ==========================================================
    // Synchronisers for line inputs
    logic [2:0] sy1_r;
    logic [2:0] sy2_r;
    logic       telco_d_r;
    always_ff @(posedge aclk)
    begin
        sy1_r     <= {link_setup, telco_lb_cmd, far_crc4};
        sy2_r     <= sy1_r;
        telco_d_r <= sy2_r[1];
    end
    wire far_crc4_s = sy2_r[0];
    wire telco_rise = sy2_r[1] & ~telco_d_r;
    wire link_s     = sy2_r[2];

    // ==========================================================
    // State
    logic [5:0]  sys_r;
    logic [6:0]  dur_r;
    logic [PW-1:0] psel_r;
    logic [7:0]  copy_r;
    logic [3:0]  istat_r;
    logic [3:0]  imask_r;
    logic [6:0]  cfg_r [NPORT];
    logic [15:0] pid_r [NPORT];
    e1pc_test_t  tst_r;
    logic [31:0] presc_r;
    logic [6:0]  mins_r;

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        logic [31:0] m;
        m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    // ==========================================================
    // AXI4-Lite write path
    logic [5:0]  wa_r;
    logic [31:0] wd_r;
    logic [3:0]  ws_r;
    wire aw_hs  = awvalid & awready;
    wire w_hs   = wvalid & wready;
    wire do_wr  = ~awready & ~wready & ~bvalid;
    wire b_hs   = bvalid & bready;
    wire wr_sys  = do_wr & (wa_r == OFS_SYS);
    wire wr_dur  = do_wr & (wa_r == OFS_DUR);
    wire wr_psel = do_wr & (wa_r == OFS_PSEL);
    wire wr_pcfg = do_wr & (wa_r == OFS_PCFG);
    wire wr_pid  = do_wr & (wa_r == OFS_PID);
    wire wr_copy = do_wr & (wa_r == OFS_COPY);
    wire wr_ist  = do_wr & (wa_r == OFS_ISTAT);
    wire wr_imk  = do_wr & (wa_r == OFS_IMASK);
    wire wr_ok   = wr_sys | wr_dur | wr_psel | wr_pcfg | wr_pid | wr_copy
                 | wr_ist | wr_imk | (wa_r == OFS_STAT);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= RESP_OK;
            wa_r    <= '0;
            wd_r    <= '0;
            ws_r    <= '0;
        end
        else
        begin
            if (aw_hs)
            begin
                awready <= 1'b0;
                wa_r    <= awaddr;
            end
            if (w_hs)
            begin
                wready <= 1'b0;
                wd_r   <= wdata;
                ws_r   <= wstrb;
            end
            if (do_wr)
            begin
                bvalid <= 1'b1;
                bresp  <= wr_ok ? RESP_OK : RESP_ERR;
            end
            if (b_hs)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    wire [31:0] wv_sys  = merge({26'h0, sys_r}, wd_r, ws_r);
    wire [31:0] wv_cfg  = merge({25'h0, cfg_r[psel_r]}, wd_r, ws_r);
    wire [31:0] wv_dur  = merge({25'h0, dur_r}, wd_r, ws_r);
    wire        sel_en  = cfg_r[psel_r][CFG_EN];
    wire        role_chg = wr_sys & (wv_sys[SYS_ROLE_NT] != sys_r[SYS_ROLE_NT]);

    // Clamp keeps the timer from ever seeing zero or beyond two hours
    wire [6:0] dur_new = (wv_dur[6:0] < DUR_MIN) ? DUR_MIN :
                         (wv_dur[6:0] > DUR_MAX) ? DUR_MAX : wv_dur[6:0];

    // ==========================================================
    // System registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sys_r   <= SYS_RST;
            dur_r   <= DUR_RST;
            psel_r  <= '0;
            imask_r <= '0;
        end
        else
        begin
            if (wr_sys)
                sys_r <= wv_sys[5:0];
            if (wr_dur)
                dur_r <= dur_new;
            if (wr_psel)
                psel_r <= wd_r[PW-1:0];
            if (wr_imk)
                imask_r <= wd_r[3:0];
        end
    end

    // ==========================================================
    // Port configuration and copy engine
    wire [PW-1:0] cp_src  = wd_r[PW-1:0];
    wire [PW-1:0] cp_dst  = wd_r[3+PW-1:3];
    wire          cp_all  = wd_r[CP_ALL];
    wire [PW-1:0] cp_next = cp_dst + PW'(1);

    // Disabled ports only accept the enable bit and PID writes; nothing else is cleared
    for (genvar p = 0; p < NPORT; p++)
    begin : g_port
        wire tgt = wr_copy & (cp_all | (cp_dst == PW'(p)));
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                cfg_r[p] <= CFG_RST;
                pid_r[p] <= '0;
            end
            else if (wr_pcfg && psel_r == PW'(p))
            begin
                cfg_r[p][CFG_EN] <= wv_cfg[CFG_EN];
                if (sel_en)
                    cfg_r[p][6:1] <= wv_cfg[6:1];
            end
            else if (tgt && cfg_r[p][CFG_EN])
                cfg_r[p] <= cfg_r[cp_src];
            else if (wr_pid && psel_r == PW'(p))
                pid_r[p] <= 16'(merge({16'h0, pid_r[p]}, wd_r, ws_r));
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            copy_r <= '0;
        else if (wr_copy)
            copy_r <= {wd_r[7:6], (wd_r[CP_INCR] && !cp_all) ? cp_next : cp_dst,
                       cp_src};
    end

    // ==========================================================
    // Derived per-port controls
    wire role_nt = sys_r[SYS_ROLE_NT];
    wire crc4_ok = ~role_nt & ~sys_r[SYS_AUTO] & sys_r[SYS_R2064];
    logic [NPORT-1:0] en_n, fr_n, by_n, ami_n, crc_n, clk_n;
    logic [2*NPORT-1:0] ts_n;
    always_comb
    begin
        for (int p = 0; p < NPORT; p++)
        begin
            en_n[p]  = cfg_r[p][CFG_EN];
            fr_n[p]  = ~cfg_r[p][CFG_UNFR];
            by_n[p]  = cfg_r[p][CFG_UNFR];
            ami_n[p] = cfg_r[p][CFG_AMI];
            crc_n[p] = fr_n[p] & (role_nt ? far_crc4_s
                                          : (crc4_ok & cfg_r[p][CFG_CRC4]));
            ts_n[2*p +: 2] = cfg_r[p][CFG_TS16 +: 2];
            clk_n[p] = ~role_nt & cfg_r[p][CFG_CLKLN];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port_en    <= '0;
            framing_on <= '0;
            whole_line_bypass_mode <= '0;
            line_ami   <= '0;
            crc4_on    <= '0;
            ts16_mode  <= '0;
            clk_from_line <= '0;
            alarm_out  <= '0;
            led_out    <= '0;
        end
        else
        begin
            port_en    <= en_n;
            framing_on <= fr_n;
            whole_line_bypass_mode <= by_n;
            line_ami   <= ami_n;
            crc4_on    <= crc_n;
            ts16_mode  <= ts_n;
            clk_from_line <= clk_n;
            alarm_out  <= alarm_in & en_n;
            led_out    <= led_req & en_n;
        end
    end

    // ==========================================================
    // Role, test timer and telco loopback
    wire telco_go = telco_rise & sys_r[SYS_TELCO];
    wire start    = test_start | telco_go;
    wire tick     = (presc_r == 32'(MIN_CYC - 1));
    wire expire   = (tst_r == E1PC_RUN) & sys_r[SYS_TMO_EN] & (mins_r >= dur_r);
    wire stop     = test_stop | expire;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tst_r   <= E1PC_IDLE;
            presc_r <= '0;
            mins_r  <= '0;
        end
        else if (start)
        begin
            tst_r   <= E1PC_RUN;
            presc_r <= '0;
            mins_r  <= '0;
        end
        else if (stop)
            tst_r <= E1PC_IDLE;
        else if (tst_r == E1PC_RUN)
        begin
            presc_r <= tick ? '0 : presc_r + 32'd1;
            if (tick && mins_r != DUR_MAX)
                mins_r <= mins_r + 7'd1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lb_local     <= 1'b0;
            lb_remote    <= 1'b0;
            test_active  <= 1'b0;
            card_reset   <= 1'b0;
            addr_request <= 1'b0;
        end
        else
        begin
            if (telco_go)
            begin
                lb_remote <= sys_r[SYS_REMOTE];
                lb_local  <= ~sys_r[SYS_REMOTE];
            end
            else if (stop || test_start)
            begin
                lb_remote <= 1'b0;
                lb_local  <= 1'b0;
            end
            test_active  <= (start | (tst_r == E1PC_RUN)) & ~(stop & ~start);
            card_reset   <= role_chg;
            addr_request <= role_nt & link_s;
        end
    end

    // ==========================================================
    // Interrupts: set wins over write-one-to-clear
    wire [3:0] ev_set = {role_chg, wr_copy, telco_go, expire};
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            istat_r <= '0;
            irq     <= 1'b0;
        end
        else
        begin
            istat_r <= (istat_r & ~(wr_ist ? wd_r[3:0] : 4'h0)) | ev_set;
            irq     <= |(((istat_r & ~(wr_ist ? wd_r[3:0] : 4'h0)) | ev_set) & imask_r);
        end
    end

    // ==========================================================
    // AXI4-Lite read path
    logic [31:0] rd_mux;
    always_comb
    begin
        unique case (araddr)
            OFS_SYS:   rd_mux = {26'h0, sys_r};
            OFS_DUR:   rd_mux = {25'h0, dur_r};
            OFS_PSEL:  rd_mux = 32'(psel_r);
            OFS_PCFG:  rd_mux = {25'h0, cfg_r[psel_r]};
            OFS_PID:   rd_mux = {16'h0, pid_r[psel_r]};
            OFS_COPY:  rd_mux = {24'h0, copy_r};
            OFS_STAT:  rd_mux = {17'h0, mins_r, 6'h0, role_nt, tst_r == E1PC_RUN};
            OFS_ISTAT: rd_mux = {28'h0, istat_r};
            OFS_IMASK: rd_mux = {28'h0, imask_r};
            default:   rd_mux = 32'h0;
        endcase
    end
    wire rd_ok = (araddr <= OFS_IMASK) && (araddr[1:0] == 2'h0);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OK;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_mux;
            rresp   <= rd_ok ? RESP_OK : RESP_ERR;
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ==========================================================
    // Assertions
    led_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !en_n[0] |=> !led_out[0] && !alarm_out[0])
        else $error("LED or alarm active on disabled port");
    unframe_byp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_r[0][CFG_UNFR] |=> whole_line_bypass_mode[0] && !framing_on[0])
        else $error("Unframed port not in bypass");
    crc4_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!role_nt && !crc4_ok) |=> !crc4_on[0])
        else $error("CRC4 outside allowed case");
    nt_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (role_nt && fr_n[0]) |=> crc4_on[0] == $past(far_crc4_s))
        else $error("NT framing does not follow far end");
    clk_lt_a: assert property (@(posedge aclk) disable iff (!aresetn)
        role_nt |=> !clk_from_line[0])
        else $error("Line clock chosen in NT role");
    role_rst_a: assert property (@(posedge aclk) disable iff (!aresetn)
        role_chg |=> card_reset ##1 !card_reset)
        else $error("Role change did not pulse card reset");
    tmo_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (expire && !start) |=> tst_r == E1PC_IDLE ##1 !test_active)
        else $error("Test kept running after expiry");
    no_tmo_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (tst_r == E1PC_RUN && !sys_r[SYS_TMO_EN] && !test_stop) |=> tst_r == E1PC_RUN)
        else $error("Test ended with timeout disabled");
    dur_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
        dur_r >= DUR_MIN && dur_r <= DUR_MAX)
        else $error("Duration out of range");
    telco_dis_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (telco_rise && !sys_r[SYS_TELCO] && !lb_local && !lb_remote) |=> !lb_local && !lb_remote)
        else $error("Telco loopback taken while disabled");
    telco_where_a: assert property (@(posedge aclk) disable iff (!aresetn)
        telco_go |=> lb_remote == $past(sys_r[SYS_REMOTE]) && lb_local != lb_remote)
        else $error("Telco loopback in wrong place");
    timer_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        start |=> mins_r == 7'd0 && presc_r == 32'd0)
        else $error("Timer not restarted on test start");

endmodule

`default_nettype wire

// [verif/e1pc_line_model.sv]
// Purpose: Far side of the E1 port: framing of far end, telco commands, link setup
// Assumes: Bench commands it by levels; lines change off the bench clock edge
// Notes:   Loopback command is a short burst, driven on the falling edge of aclk
`default_nettype none

module e1pc_line_model (
    // Bench commands
    input  wire logic aclk,
    input  wire logic crc4_cmd,
    input  wire logic lb_cmd,
    input  wire logic setup_cmd,
    // Line side
    output logic      far_crc4,
    output logic      telco_lb_cmd,
    output logic      link_setup
);
    timeunit 1ns;
    timeprecision 1ns;
    int hold = 0;
    // ==========================================================
    // Falling edge keeps the lines asynchronous to the sampler
    always @(negedge aclk)
    begin
        far_crc4 <= crc4_cmd;
        link_setup <= setup_cmd;
        hold <= lb_cmd ? 4 : (hold > 0 ? hold - 1 : 0);
        telco_lb_cmd <= (hold > 1);
    end
endmodule

`default_nettype wire

// [verif/e1pc_top_tb_top.sv]
// Purpose: Self-checking bench for the E1 port and test configuration block
// Assumes: AXI4-Lite master tasks; minute shortened to 20 cycles
// Notes:   Expectations come from the integer model below
`default_nettype none

module e1pc_top_tb_top;
    import e1pc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MC = 20;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic rready = 0, test_start = 0, test_stop = 0, crc4_cmd = 0, lb_cmd = 0;
    logic setup_cmd = 0, awready, wready, bvalid, arready, rvalid, far_crc4;
    logic telco_lb_cmd, link_setup, card_reset, addr_request, test_active;
    logic lb_local, lb_remote, irq;
    logic [5:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rdv;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, rsp;
    logic [7:0] alarm_in = 0, led_req = 0, port_en, framing_on, whole_line_bypass_mode;
    logic [7:0] line_ami, crc4_on, clk_from_line, alarm_out, led_out;
    logic [15:0] ts16_mode;
    logic [16:0] rnd = 17'd81885;
    int err_total = 0, checks_done = 0, m_cfg[8], m_sys = 'h18, m_far = 0, rst_seen = 0;
    int n;

    always #50 aclk = ~aclk;
    always @(posedge aclk) if (card_reset === 1'b1) rst_seen <= rst_seen + 1;

    e1pc_top #(.NPORT(8), .MIN_CYC(MC)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .far_crc4, .telco_lb_cmd, .link_setup,
        .alarm_in, .led_req, .test_start, .test_stop, .port_en, .framing_on,
        .whole_line_bypass_mode, .line_ami, .crc4_on, .ts16_mode, .clk_from_line,
        .alarm_out, .led_out, .card_reset, .addr_request, .test_active, .lb_local,
        .lb_remote, .irq);
    e1pc_line_model line (.aclk, .crc4_cmd, .lb_cmd, .setup_cmd, .far_crc4,
        .telco_lb_cmd, .link_setup);

    // ==========================================================
    // Helpers
    function automatic logic [16:0] nx(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        int i;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 0;
            if (wready === 1'b1) wvalid <= 0;
            if (bvalid === 1'b1) break;
        end
        chk("bresp", RESP_OK, bresp);
        bready <= 0;
        if (i == 50)
        begin
            err_total++;
            conclude();
        end
        @(posedge aclk);
    endtask
    task automatic rd(input logic [5:0] a);
        int i;
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 0;
            if (rvalid === 1'b1) break;
        end
        rdv = rdata;
        rsp = rresp;
        rready <= 0;
        if (i == 50)
        begin
            err_total++;
            conclude();
        end
        @(posedge aclk);
    endtask
    task automatic pcfg(input int p, input int v);
        wr(OFS_PSEL, p);
        wr(OFS_PCFG, v);
        m_cfg[p] = (m_cfg[p] & 1) ? (v & 'h7f) : ((m_cfg[p] & 'h7e) | (v & 1));
        cyc(2);
    endtask
    task automatic outs(input int p);
        int c, nt;
        c = m_cfg[p];
        nt = m_sys & 1;
        chk("port_en", c & 1, port_en[p]);
        chk("framing_on", ~c >> 1 & 1, framing_on[p]);
        chk("bypass", c >> 1 & 1, whole_line_bypass_mode[p]);
        chk("line_ami", c >> 2 & 1, line_ami[p]);
        chk("ts16_mode", c >> 4 & 3, ts16_mode[2*p+:2]);
        chk("clk_from_line", (nt ^ 1) & c >> 6 & 1, clk_from_line[p]);
        chk("crc4_on", (~c >> 1 & 1) & (nt ? m_far : (c >> 3 & 1) & (~m_sys >> 1 & 1)
            & (m_sys >> 2 & 1)), crc4_on[p]);
    endtask
    task automatic sys(input int v);
        wr(OFS_SYS, v);
        m_sys = v;
        cyc(2);
    endtask
    task automatic pulse(input int k);
        if (k == 0) test_start <= 1; else test_stop <= 1;
        @(posedge aclk);
        {test_start, test_stop} <= 2'b00;
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        foreach (m_cfg[i]) m_cfg[i] = 'h11;
        cyc(16);
        aresetn <= 1;
        cyc(2);
        for (n = 0; n < 8; n++) outs(n);
        rd(OFS_SYS);
        chk("sys", 'h18, rdv);
        rd(OFS_DUR);
        chk("dur", 10, rdv);
        $display("reset values done");
        rnd = nx(rnd);
        foreach (m_cfg[i]) if (i < 3) // zero, too large, random legal value
        begin
            n = (i == 0) ? 0 : (i == 1) ? 125 : rnd % 120 + 1;
            wr(OFS_DUR, n);
            rd(OFS_DUR);
            chk("dur", n < 1 ? 1 : (n > 120 ? 120 : n), rdv);
        end
        $display("duration done");
        pcfg(2, 'h67);
        outs(2);
        pcfg(3, 'h19);
        outs(3);
        sys('h1c);
        outs(3);
        sys('h1e);
        outs(3);
        sys('h18);
        pcfg(3, 'h18);
        pcfg(3, 'h1c);
        rd(OFS_PCFG);
        chk("pcfg_locked", m_cfg[3], rdv);
        rnd = nx(rnd);
        alarm_in <= rnd[7:0];
        led_req <= ~rnd[7:0];
        cyc(3);
        chk("alarm_out", rnd[7:0] & 8'hf7, alarm_out);
        chk("led_out", ~rnd[7:0] & 8'hf7, led_out);
        outs(3);
        $display("port options done");
        rnd = nx(rnd);
        wr(OFS_PSEL, 0);
        wr(OFS_PID, rnd[15:0]);
        wr(OFS_COPY, 'h02);
        m_cfg[0] = m_cfg[2];
        cyc(2);
        outs(0);
        rd(OFS_PID);
        chk("pid_kept", rnd[15:0], rdv[15:0]);
        rd(OFS_ISTAT);
        chk("copy_event", 1, rdv[EV_COPY]);
        chk("irq_masked", 0, irq);
        wr(OFS_IMASK, 4);
        cyc(3);
        chk("irq_on", 1, irq);
        wr(OFS_ISTAT, 'hf);
        cyc(3);
        chk("irq_off", 0, irq);
        wr(OFS_COPY, 'h8a);
        m_cfg[1] = m_cfg[2];
        rd(OFS_COPY);
        chk("copy_incr", 'h92, rdv[7:0]);
        $display("copy done");
        wr(OFS_DUR, 2);
        pulse(0);
        cyc(1);
        for (n = 0; n < 100 && test_active !== 1'b0; n++) @(posedge aclk);
        chk("expiry_window", 1, n >= 36 && n <= 44);
        rd(OFS_ISTAT);
        chk("tmo_event", 1, rdv[EV_TMO]);
        pulse(0);
        cyc(30);
        pulse(0);
        cyc(30);
        chk("restart", 1, test_active);
        sys('h10);
        pulse(0);
        cyc(60);
        chk("no_timeout", 1, test_active);
        pulse(1);
        cyc(3);
        chk("stopped", 0, test_active);
        $display("timer done");
        for (n = 0; n < 3; n++) // local, remote, refused
        begin
            sys(n == 0 ? 'h18 : (n == 1 ? 'h38 : 'h08));
            lb_cmd <= 1;
            @(posedge aclk);
            lb_cmd <= 0;
            cyc(10);
            chk("lb_local", n == 0, lb_local);
            chk("lb_remote", n == 1, lb_remote);
            pulse(1);
            cyc(3);
        end
        $display("telco loopback done");
        crc4_cmd <= 1;
        setup_cmd <= 1;
        m_far = 1;
        n = rst_seen;
        sys('h19);
        cyc(4);
        chk("card_reset", n + 1, rst_seen);
        chk("addr_request", 1, addr_request);
        for (n = 0; n < 8; n++) outs(n);
        rd(6'h3c);
        chk("unmapped", {30'h0, RESP_ERR}, {rdv[29:0], rsp});
        $display("role and bus done");
        conclude();
    end
endmodule

`default_nettype wire
